// *** sg_regfile.sv ***
// Register file and bus interface of the three-channel sound generator.
`timescale 1ns/1ns
`include "sg_regs.svh"

module sg_regfile
  import sg_pkg::*;
(
  // Clock, enable and reset.
  input  wire logic        CLK,
  input  wire logic        CE,
  input  wire logic        RESETN,
  // Bus control and data.
  input  wire logic        BUS_DIRECTION,
  input  wire logic        BUS_CONTROL_ONE,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE_N,
  // I/O port A input and port B output.
  input  wire logic [7:0]  PORT_A_IN,
  output logic      [7:0]  PORT_B_OUT,
  output logic             JOYSTICK_SELECT,
  // Settings presented to the tone, noise and envelope logic.
  output logic      [11:0] TONE_PERIOD_A,
  output logic      [11:0] TONE_PERIOD_B,
  output logic      [11:0] TONE_PERIOD_C,
  output logic      [4:0]  NOISE_PERIOD,
  output logic      [2:0]  TONE_ON,
  output logic      [2:0]  NOISE_ON,
  output logic      [3:0]  FIXED_LEVEL_A,
  output logic      [3:0]  FIXED_LEVEL_B,
  output logic      [3:0]  FIXED_LEVEL_C,
  output logic      [2:0]  USE_ENVELOPE,
  output logic      [15:0] ENVELOPE_PERIOD,
  output logic      [3:0]  ENVELOPE_SHAPE
);

  // ****************************************************************
  // State type.
  // ****************************************************************
  // State of the block past the reset and input synchronisers, registered as one word.
  typedef struct packed {
    logic [3:0]  index;
    sg_byte_t [15:0] regs;
    logic [7:0]  dout;
    logic        oe_n;
    logic [11:0] tone_a;
    logic [11:0] tone_b;
    logic [11:0] tone_c;
    logic [4:0]  noise;
    logic [2:0]  tone_on;
    logic [2:0]  noise_on;
    logic [3:0]  lvl_a;
    logic [3:0]  lvl_b;
    logic [3:0]  lvl_c;
    logic [2:0]  use_env;
    logic [15:0] env_period;
    logic [3:0]  env_shape;
  } sg_state_t;

  // ****************************************************************
  // Reset release and input synchronisation.
  // ****************************************************************
  logic       rst_meta_ff;     // First stage of reset release.
  logic       rst_sync_ff;     // Released reset used by the design.
  logic [1:0] ctl_sync;        // Synchronised direction and control-one.
  logic [7:0] din_sync;        // Synchronised data bus.
  logic [7:0] porta_sync;      // Synchronised port A pins.
  sg_bus_op_t bus_op;          // Decoded bus action.
  sg_state_t  state_ff;        // Registered state.
  sg_state_t  nxt_state;       // Next state.

  // Reset asserts at once and releases through two flip-flops.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Bus controls come from the host glue, outside this clock.
  sg_sync #(.WIDTH(2)) u_ctl_sync (
    .clk   (CLK),
    .ce    (CE),
    .rst_n (rst_sync_ff),
    .d     ({BUS_DIRECTION, BUS_CONTROL_ONE}),
    .q     (ctl_sync)
  );

  // Data bus and port A pins, grouped in one synchroniser.
  sg_sync #(.WIDTH(16)) u_data_sync (
    .clk   (CLK),
    .ce    (CE),
    .rst_n (rst_sync_ff),
    .d     ({DATA_IN, PORT_A_IN}),
    .q     ({din_sync, porta_sync})
  );

  // Decoder of the bus action.
  sg_bus_decode u_decode (
    .bus_direction   (ctl_sync[1]),
    .bus_control_one (ctl_sync[0]),
    .bus_op          (bus_op)
  );

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Carries out the bus action and derives the settings outputs.
  always_comb begin
    sg_byte_t [15:0] r;
    r         = state_ff.regs;
    nxt_state = state_ff;
    // Port A is an input: its register mirrors the pins.
    r[`SG_IDX_IO_PORT_A] = porta_sync;
    case (bus_op)
      SG_BUS_LATCH: begin
        // Index stays until the next latch.
        nxt_state.index = din_sync[3:0];
        nxt_state.oe_n  = 1'b1;
      end
      SG_BUS_WRITE: begin
        // Write goes to the latched index, port A stays read-only.
        if (state_ff.index != `SG_IDX_IO_PORT_A) begin
          r[state_ff.index] = din_sync;
        end
        nxt_state.oe_n = 1'b1;
      end
      SG_BUS_READ: begin
        // Drive the selected register onto the data bus.
        nxt_state.dout = r[state_ff.index];
        nxt_state.oe_n = 1'b0;
      end
      default: begin
        // Idle releases the data bus.
        nxt_state.oe_n = 1'b1;
      end
    endcase
    // Narrow registers keep only their documented width, upper bits zero.
    r[`SG_IDX_TONE_A_COARSE] = {4'h0, r[`SG_IDX_TONE_A_COARSE][3:0]};
    r[`SG_IDX_TONE_B_COARSE] = {4'h0, r[`SG_IDX_TONE_B_COARSE][3:0]};
    r[`SG_IDX_TONE_C_COARSE] = {4'h0, r[`SG_IDX_TONE_C_COARSE][3:0]};
    r[`SG_IDX_NOISE_PERIOD]  = {3'h0, r[`SG_IDX_NOISE_PERIOD][4:0]};
    r[`SG_IDX_LEVEL_A]       = {3'h0, r[`SG_IDX_LEVEL_A][4:0]};
    r[`SG_IDX_LEVEL_B]       = {3'h0, r[`SG_IDX_LEVEL_B][4:0]};
    r[`SG_IDX_LEVEL_C]       = {3'h0, r[`SG_IDX_LEVEL_C][4:0]};
    r[`SG_IDX_ENV_SHAPE]     = {4'h0, r[`SG_IDX_ENV_SHAPE][3:0]};
    nxt_state.regs = r;
    // Tone periods: coarse bits above fine bits.
    nxt_state.tone_a = {r[`SG_IDX_TONE_A_COARSE][3:0], r[`SG_IDX_TONE_A_FINE]};
    nxt_state.tone_b = {r[`SG_IDX_TONE_B_COARSE][3:0], r[`SG_IDX_TONE_B_FINE]};
    nxt_state.tone_c = {r[`SG_IDX_TONE_C_COARSE][3:0], r[`SG_IDX_TONE_C_FINE]};
    nxt_state.noise  = r[`SG_IDX_NOISE_PERIOD][4:0];
    // Mask is active low: a zero bit turns its source on.
    nxt_state.tone_on  = ~r[`SG_IDX_SOURCE_ENABLE][2:0];
    nxt_state.noise_on = ~r[`SG_IDX_SOURCE_ENABLE][5:3];
    // Envelope select forces the fixed level to zero, as bits 0-3 are ignored.
    nxt_state.use_env = {r[`SG_IDX_LEVEL_C][`SG_LEVEL_ENV_BIT],
                         r[`SG_IDX_LEVEL_B][`SG_LEVEL_ENV_BIT],
                         r[`SG_IDX_LEVEL_A][`SG_LEVEL_ENV_BIT]};
    nxt_state.lvl_a = r[`SG_IDX_LEVEL_A][`SG_LEVEL_ENV_BIT] ? 4'h0
                                                            : r[`SG_IDX_LEVEL_A][3:0];
    nxt_state.lvl_b = r[`SG_IDX_LEVEL_B][`SG_LEVEL_ENV_BIT] ? 4'h0
                                                            : r[`SG_IDX_LEVEL_B][3:0];
    nxt_state.lvl_c = r[`SG_IDX_LEVEL_C][`SG_LEVEL_ENV_BIT] ? 4'h0
                                                            : r[`SG_IDX_LEVEL_C][3:0];
    nxt_state.env_period = {r[`SG_IDX_ENV_HIGH], r[`SG_IDX_ENV_LOW]};
    nxt_state.env_shape  = r[`SG_IDX_ENV_SHAPE][3:0];
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Reset loads the all-sources-off mask; the enable freezes all state.
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff                              <= '0;
      state_ff.oe_n                         <= 1'b1;
      state_ff.regs[`SG_IDX_SOURCE_ENABLE]  <= `SG_RST_ENABLE_MASK;
      state_ff.tone_on                      <= 3'h0;
      state_ff.noise_on                     <= 3'h0;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // Every output is a field of the registered state.
  assign DATA_OUT        = state_ff.dout;
  assign DATA_OE_N       = state_ff.oe_n;
  assign PORT_B_OUT      = state_ff.regs[`SG_IDX_IO_PORT_B];
  assign JOYSTICK_SELECT = state_ff.regs[`SG_IDX_IO_PORT_B][`SG_PORTB_SEL_BIT];
  assign TONE_PERIOD_A   = state_ff.tone_a;
  assign TONE_PERIOD_B   = state_ff.tone_b;
  assign TONE_PERIOD_C   = state_ff.tone_c;
  assign NOISE_PERIOD    = state_ff.noise;
  assign TONE_ON         = state_ff.tone_on;
  assign NOISE_ON        = state_ff.noise_on;
  assign FIXED_LEVEL_A   = state_ff.lvl_a;
  assign FIXED_LEVEL_B   = state_ff.lvl_b;
  assign FIXED_LEVEL_C   = state_ff.lvl_c;
  assign USE_ENVELOPE    = state_ff.use_env;
  assign ENVELOPE_PERIOD = state_ff.env_period;
  assign ENVELOPE_SHAPE  = state_ff.env_shape;

endmodule : sg_regfile

// *** sg_regs.svh ***
// Register indices, field positions, widths and reset values of the sound generator.
`ifndef SG_REGS_SVH
`define SG_REGS_SVH

// ****************************************************************
// Register indices.
// ****************************************************************
`define SG_IDX_TONE_A_FINE     4'h0
`define SG_IDX_TONE_A_COARSE   4'h1
`define SG_IDX_TONE_B_FINE     4'h2
`define SG_IDX_TONE_B_COARSE   4'h3
`define SG_IDX_TONE_C_FINE     4'h4
`define SG_IDX_TONE_C_COARSE   4'h5
`define SG_IDX_NOISE_PERIOD    4'h6
`define SG_IDX_SOURCE_ENABLE   4'h7
`define SG_IDX_LEVEL_A         4'h8
`define SG_IDX_LEVEL_B         4'h9
`define SG_IDX_LEVEL_C         4'ha
`define SG_IDX_ENV_LOW         4'hb
`define SG_IDX_ENV_HIGH        4'hc
`define SG_IDX_ENV_SHAPE       4'hd
`define SG_IDX_IO_PORT_A       4'he
`define SG_IDX_IO_PORT_B       4'hf

// ****************************************************************
// Field positions and widths.
// ****************************************************************
`define SG_COARSE_W            4
`define SG_FINE_W              8
`define SG_NOISE_W             5
`define SG_LEVEL_W             5
`define SG_SHAPE_W             4
`define SG_LEVEL_ENV_BIT       4
`define SG_PORTB_SEL_BIT       7

// ****************************************************************
// Reset values.
// ****************************************************************
`define SG_RST_ENABLE_MASK     8'h3f
`define SG_RST_ZERO            8'h00
`define SG_RST_INDEX           4'h0

`endif

// *** sg_pkg.sv ***
// Types shared by the sound generator register block.
package sg_pkg;

  // Bus-control action decoded from direction and control-one.
  typedef enum logic [1:0] {
    SG_BUS_IDLE,
    SG_BUS_READ,
    SG_BUS_WRITE,
    SG_BUS_LATCH
  } sg_bus_op_t;

  // One register byte.
  typedef logic [7:0] sg_byte_t;

endpackage : sg_pkg

// *** sg_bus_decode.sv ***
// Bus-control decoder of the sound generator.
`timescale 1ns/1ns
module sg_bus_decode
  import sg_pkg::*;
(
  // Synchronised control levels.
  input  wire logic       bus_direction,
  input  wire logic       bus_control_one,
  // Decoded action.
  output sg_bus_op_t      bus_op
);

  // ****************************************************************
  // Decode.
  // ****************************************************************
  // Maps the two control levels onto the four bus actions.
  always_comb begin
    case ({bus_direction, bus_control_one})
      2'b11:   bus_op = SG_BUS_LATCH;
      2'b10:   bus_op = SG_BUS_WRITE;
      2'b01:   bus_op = SG_BUS_READ;
      default: bus_op = SG_BUS_IDLE;
    endcase
  end

endmodule : sg_bus_decode

// *** sg_sync.sv ***
// Two-flip-flop synchroniser for a group of pin levels.
`timescale 1ns/1ns
module sg_sync #(
  parameter int WIDTH = 1
) (
  // Clock, enable and reset.
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             rst_n,
  // Raw and synchronised levels.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta_ff;

  // Both stages clear to zero under reset and hold while disabled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : sg_sync

// *** sg_regfile_checker.sv ***
// Concurrent checks on the ports of the sound generator register block.
`timescale 1ns/1ns
module sg_regfile_checker
  import sg_pkg::*;
(
  // Clock, reset and bus controls.
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        BUS_DIRECTION,
  input  wire logic        BUS_CONTROL_ONE,
  // Read path, port B and settings.
  input  wire logic [7:0]  DATA_OUT,
  input  wire logic        DATA_OE_N,
  input  wire logic [7:0]  PORT_B_OUT,
  input  wire logic        JOYSTICK_SELECT,
  input  wire logic [11:0] TONE_PERIOD_A,
  input  wire logic [4:0]  NOISE_PERIOD,
  input  wire logic [2:0]  TONE_ON,
  input  wire logic [2:0]  NOISE_ON,
  input  wire logic [3:0]  FIXED_LEVEL_A,
  input  wire logic [2:0]  USE_ENVELOPE,
  input  wire logic [15:0] ENVELOPE_PERIOD
);
  // Write and read codes delayed by the three-edge input latency.
  logic [2:0] wr_ff;
  logic [2:0] rd_ff;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_ff <= 3'h0;
      rd_ff <= 3'h0;
    end else begin
      wr_ff <= {wr_ff[1:0], BUS_DIRECTION & ~BUS_CONTROL_ONE};
      rd_ff <= {rd_ff[1:0], ~BUS_DIRECTION & BUS_CONTROL_ONE};
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  read_enable_a: assert property (DATA_OE_N == !rd_ff[2])
    else $error("data enable does not follow the read code");
  oe_span_a: assert property ($fell(DATA_OE_N) |-> !DATA_OE_N [*3])
    else $error("data enable dropped inside a held read");
  data_out_read_a: assert property ($changed(DATA_OUT) |-> rd_ff[2])
    else $error("read data changed without a read");
  mask_write_a: assert property ($changed({TONE_ON, NOISE_ON}) |-> wr_ff[2])
    else $error("source enables changed without a write");
  setting_hold_a: assert property (!wr_ff[2] |->
    $stable({ENVELOPE_PERIOD, NOISE_PERIOD, TONE_PERIOD_A}))
    else $error("a setting changed without a write");
  port_b_write_a: assert property ($changed(PORT_B_OUT) |-> wr_ff[2])
    else $error("port B changed without a write");
  joy_select_a: assert property (JOYSTICK_SELECT == PORT_B_OUT[7])
    else $error("joystick select differs from port B bit 7");
  env_level_a: assert property (USE_ENVELOPE[0] |-> FIXED_LEVEL_A == 4'h0)
    else $error("fixed level kept while envelope selected");
endmodule : sg_regfile_checker
bind sg_regfile sg_regfile_checker u_sg_regfile_checker (.*);

// *** sg_host_glue.sv ***
// Host-side bus glue and joystick selector facing the register block.
`timescale 1ns/1ns
module sg_host_glue (
  // Host address, strobe and chip decode.
  input  wire logic [1:0] addr,
  input  wire logic       io_request_n,
  input  wire logic       select_n,
  // Control levels to the block.
  output logic            bus_direction,
  output logic            bus_control_one,
  // Joystick connectors and port A pins.
  input  wire logic       joy_sel,
  input  wire logic [7:0] joystick_connector_one,
  input  wire logic [7:0] joystick_connector_two,
  output logic      [7:0] port_a
);
  // Controls are the inverted address bits while decoded, otherwise idle.
  assign bus_direction   = !select_n && !io_request_n && !addr[1];
  assign bus_control_one = !select_n && !io_request_n && !addr[0];
  // Port B bit 7 routes one connector into port A, which is only read.
  assign port_a = joy_sel ? joystick_connector_two : joystick_connector_one;
endmodule : sg_host_glue

// *** tb_sound_generator_regs.sv ***
// Self-checking bench for the sound generator register block.
`timescale 1ns/1ns
module tb_sound_generator_regs
  import sg_pkg::*;
;
  logic        CLK = 0, RESETN = 0, io_request_n = 1, select_n = 1, dir, c1, joy_sel, oe_n;
  logic        ce = 1'b1;
  logic [1:0]  addr = 2'h3;
  sg_byte_t    data_in = 8'h00, port_a, data_out, port_b, joy1 = 8'h5a, joy2 = 8'hc3;
  logic [11:0] tpa, tpb, tpc;
  logic [4:0]  noise;
  logic [2:0]  tone_on, noise_on, use_env;
  logic [3:0]  fla, flb, flc, shape;
  logic [15:0] env;
  int          num_errors = 0, checks_done = 0, cycles = 0;
  always #25 CLK = ~CLK;
  sg_host_glue u_sg_host_glue (.addr(addr), .io_request_n(io_request_n), .select_n(select_n),
    .bus_direction(dir), .bus_control_one(c1), .joy_sel(joy_sel),
    .joystick_connector_one(joy1), .joystick_connector_two(joy2), .port_a(port_a));
  sg_regfile u_sg_regfile (.CLK(CLK), .CE(ce), .RESETN(RESETN), .BUS_DIRECTION(dir),
    .BUS_CONTROL_ONE(c1), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(oe_n),
    .PORT_A_IN(port_a), .PORT_B_OUT(port_b), .JOYSTICK_SELECT(joy_sel), .TONE_PERIOD_A(tpa),
    .TONE_PERIOD_B(tpb), .TONE_PERIOD_C(tpc), .NOISE_PERIOD(noise), .TONE_ON(tone_on),
    .NOISE_ON(noise_on), .FIXED_LEVEL_A(fla), .FIXED_LEVEL_B(flb), .FIXED_LEVEL_C(flc),
    .USE_ENVELOPE(use_env), .ENVELOPE_PERIOD(env), .ENVELOPE_SHAPE(shape));
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One bus cycle: code held four edges, then idle four edges.
  task automatic access(input logic [1:0] a, input sg_byte_t d, input logic sel_n = 1'b0);
    @(negedge CLK);
    addr = a;
    data_in = d;
    select_n = sel_n;
    io_request_n = 1'b0;
    repeat (4) @(negedge CLK);
    io_request_n = 1'b1;
    select_n = 1'b1;
    repeat (4) @(negedge CLK);
  endtask : access
  // Latches an index, then writes or reads it.
  task automatic wr(input logic [3:0] idx, input sg_byte_t v);
    access(2'h0, {4'h0, idx});
    access(2'h1, v);
  endtask : wr
  task automatic rd(input logic [3:0] idx, input sg_byte_t exp);
    access(2'h0, {4'h0, idx});
    access(2'h2, 8'h00);
    chk("read data", exp, data_out);
  endtask : rd
  // Reset values, then tone, noise, mask, level, envelope and ports.
  task automatic t_reset();
    chk("oe_n", 1'b1, oe_n);
    chk("tone_on", 3'h0, tone_on);
    rd(4'h7, 8'h3f);
  endtask : t_reset
  task automatic t_tone();
    for (int i = 0; i < 3; i++) begin
      wr(4'(2 * i), 8'(8'h30 + i));
      wr(4'(2 * i + 1), 8'(8'hf8 + i));
    end
    chk("tone a", 12'h830, tpa);
    chk("tone b", 12'h931, tpb);
    chk("tone c", 12'ha32, tpc);
    rd(4'h3, 8'h09);
  endtask : t_tone
  task automatic t_noise_mask();
    wr(4'h6, 8'hff);
    chk("noise", 5'h1f, noise);
    rd(4'h6, 8'h1f);
    wr(4'h7, 8'h2a);
    chk("tone_on", 3'h5, tone_on);
    chk("noise_on", 3'h2, noise_on);
    wr(4'h7, 8'h00);
    chk("all on", 6'h3f, {tone_on, noise_on});
  endtask : t_noise_mask
  task automatic t_level();
    wr(4'h8, 8'hfc);
    chk("level a env", {1'b1, 4'h0}, {use_env[0], fla});
    rd(4'h8, 8'h1c);
    wr(4'h8, 8'h0c);
    chk("level a", {1'b0, 4'hc}, {use_env[0], fla});
    wr(4'ha, 8'h17);
    chk("level c env", {3'h4, 4'h0}, {use_env, flc});
  endtask : t_level
  task automatic t_env();
    wr(4'hb, 8'h34);
    wr(4'hc, 8'h12);
    wr(4'hd, 8'hf9);
    chk("envelope", 16'h1234, env);
    chk("shape", 4'h9, shape);
  endtask : t_env
  // Enable held low freezes the block, so a whole write is lost.
  task automatic t_hold();
    ce = 1'b0;
    wr(4'h6, 8'h05);
    ce = 1'b1;
    chk("noise frozen", 5'h1f, noise);
    rd(4'h6, 8'h1f);
  endtask : t_hold
  task automatic t_ports();
    wr(4'hf, 8'h80);
    chk("port b", 8'h80, port_b);
    rd(4'he, 8'hc3);
    wr(4'hf, 8'h7f);
    wr(4'he, 8'h55);
    rd(4'he, 8'h5a);
  endtask : t_ports
  // Index persists; deselected and idle cycles leave registers alone.
  task automatic t_index();
    access(2'h0, 8'h09);
    access(2'h1, 8'h03);
    access(2'h2, 8'h00);
    chk("persist", 8'h03, data_out);
    access(2'h1, 8'h05, 1'b1);
    access(2'h3, 8'h06);
    chk("level b", 4'h3, flb);
  endtask : t_index
  task automatic t_rerst();
    @(negedge CLK);
    RESETN = 1'b0;
    repeat (8) @(negedge CLK);
    RESETN = 1'b1;
    repeat (4) @(negedge CLK);
    chk("env after reset", 16'h0000, env);
    chk("mask after reset", 6'h00, {tone_on, noise_on});
    rd(4'h7, 8'h3f);
  endtask : t_rerst
  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // Cuts a hang short.
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge CLK);
    RESETN = 1'b1;
    repeat (4) @(negedge CLK);
    t_reset();
    t_tone();
    t_noise_mask();
    t_level();
    t_env();
    t_hold();
    t_ports();
    t_index();
    t_rerst();
    summarize();
  end
endmodule : tb_sound_generator_regs
